/* hdl/irq_unit_cfg.svh */
/*
  Constants of the event interrupt unit: register offsets, reset
  values, channel layout and debounce times.
  Assumes a 10 MHz core clock.
*/
`ifndef IRQ_UNIT_CFG_SVH
`define IRQ_UNIT_CFG_SVH
// ==========================================================
// Clock and timing
`define CLK_KHZ      10000
`define TICK_US      100
`define TICK_CYC     (`TICK_US * `CLK_KHZ / 1000)
`define DEB_SHORT_US 3900
`define DEB_BTN_US   31250
`define DEB_OC_US    8000
`define CNT_W        12
// ==========================================================
// Register offsets
`define OFF_STAT0    8'h05
`define OFF_MASK0    8'h06
`define OFF_SENSE0   8'h07
`define OFF_STAT1    8'h08
`define OFF_MASK1    8'h09
`define OFF_SENSE1   8'h0A
`define MASK0_RST    6'h3F
`define MASK1_RST    7'h7F
`define PROG_BIT     7
// ==========================================================
// Channels: button, low input, 4 thermal, 5 buck, boost,
// 6 linear regulators, configuration memory
`define NCH          19
`define CH_BTN       0
`define CH_LOWV      1
`define CH_BUCK0     6
`define CH_EXT0      11
`define RISE_EN      19'h7FFFF
`define FALL_EN      19'h0003D
`endif

/* hdl/irq_unit_pkg.sv */
/*
  Types of the event interrupt unit.
  Assumes irq_unit_cfg.svh on the include path.
*/
`default_nettype none
`include "irq_unit_cfg.svh"
package irq_unit_pkg;
  typedef logic [`NCH-1:0] chan_vec_t;
  typedef logic [`CNT_W-1:0] cnt_t;
  typedef logic [7:0] byte_t;
  typedef struct packed {
    chan_vec_t             s1;
    chan_vec_t             s2;
    logic                  ps1;
    logic                  ps2;
    chan_vec_t             lvl;
    cnt_t [`NCH-1:0]       cnt;
    logic [15:0]           div;
    logic                  tick;
    chan_vec_t             ev;
    logic [5:0]            st0;
    logic [5:0]            m0;
    logic [7:0]            st1;
    logic [6:0]            m1;
    byte_t                 rdata;
  } unit_state_t;
endpackage
`default_nettype wire

/* hdl/pmic_event_interrupt_unit.sv */
/*
  Event interrupt unit: debounces 19 event inputs, latches the first 11 in
  write-one-to-clear status bits, masks them onto an active-low
  interrupt line and offers status, mask and sense registers.
  Assumes a register port from the serial interface decoder on the
  same clock, and analog comparator outputs from outside the domain.
*/
`default_nettype none
`include "irq_unit_cfg.svh"
module pmic_event_interrupt_unit #(
  parameter int TICK_DIV = `TICK_CYC // Core cycles per debounce tick
) (
  input  wire logic                core_clk_i,   // 10 MHz clock
  input  wire logic                rst_n_i,      // Sync reset
  input  wire irq_unit_pkg::byte_t reg_addr_i,   // Register offset
  input  wire irq_unit_pkg::byte_t reg_wdata_i,  // Write data
  input  wire logic                reg_wr_i,     // Write strobe
  input  wire logic                reg_rd_i,     // Read strobe
  output logic [7:0]               reg_rdata_o,  // Read data
  input  wire logic                power_button_in_i, // Button
  input  wire logic                low_input_i,  // Supply low
  input  wire logic [3:0]          hot_i,        // Thermal
  input  wire logic [4:0]          buck_oc_i,    // 1A 1B 2 3A 3B
  input  wire logic                boost_oc_i,   // Boost fault
  input  wire logic [5:0]          ldo_oc_i,     // Linear faults
  input  wire logic                cfgmem_err_i, // Memory error
  input  wire logic                prog_supply_level_i, // Pin
  input  wire logic [1:0]          button_debounce_extend_i, // Ext
  output logic                     irq_out_n_o,  // Interrupt
  output logic [7:0]               ext_level_o,  // Debounced
  output logic [7:0]               ext_event_o   // Event pulse
);
  import irq_unit_pkg::*;

  unit_state_t u_r;
  unit_state_t u_nxt;
  chan_vec_t   raw;

  // ==========================================================
  // Helpers
  function automatic logic [2:0] oc_pos(input int j);
    logic [2:0] p;
    p = 3'(j);
    if (j >= 2) begin
      p = 3'(j + 1);
    end
    return p;
  endfunction

  function automatic cnt_t ticks(input int us, input logic [1:0] x);
    int t;
    t = (us + `TICK_US - 1) / `TICK_US;
    return cnt_t'(t << x);
  endfunction

  function automatic cnt_t limit(input int ch, input logic tgt,
                                 input logic [1:0] ext);
    cnt_t l;
    l = ticks(`DEB_OC_US, 2'h0);
    if (ch == `CH_BTN) begin
      l = ticks(`DEB_BTN_US, tgt ? 2'h0 : ext);
    end else if (ch == `CH_LOWV) begin
      l = ticks(`DEB_SHORT_US, tgt ? ext : 2'h0);
    end else if (ch < `CH_BUCK0) begin
      l = ticks(`DEB_SHORT_US, 2'h0);
    end
    return l;
  endfunction

  localparam cnt_t      OC_TICKS = ticks(`DEB_OC_US, 2'h0);
  localparam chan_vec_t RISE_SEL = `RISE_EN;
  localparam chan_vec_t FALL_SEL = `FALL_EN;

  assign raw = {cfgmem_err_i, ldo_oc_i, boost_oc_i, buck_oc_i,
                hot_i, low_input_i, power_button_in_i};

  // ==========================================================
  // Next state
  always_comb begin
    cnt_t  lim;
    byte_t sense1;
    lim    = '0;
    sense1 = '0;
    u_nxt  = u_r;
    u_nxt.s1  = raw;
    u_nxt.s2  = u_r.s1;
    u_nxt.ps1 = prog_supply_level_i;
    u_nxt.ps2 = u_r.ps1;
    u_nxt.ev  = '0;
    // Slow tick keeps the counters narrow
    u_nxt.tick = 1'b0;
    if (u_r.div >= 16'(TICK_DIV - 1)) begin
      u_nxt.div  = '0;
      u_nxt.tick = 1'b1;
    end else begin
      u_nxt.div = u_r.div + 16'h0001;
    end
    for (int i = 0; i < `NCH; i++) begin
      lim = limit(i, u_r.s2[i], button_debounce_extend_i);
      if (u_r.lvl[i] == u_r.s2[i]) begin
        u_nxt.cnt[i] = '0;
      end else if (u_r.tick) begin
        if (u_r.cnt[i] >= lim - cnt_t'(1)) begin
          u_nxt.lvl[i] = u_r.s2[i];
          u_nxt.cnt[i] = '0;
          u_nxt.ev[i]  = u_r.s2[i] ? RISE_SEL[i] : FALL_SEL[i];
        end else begin
          u_nxt.cnt[i] = u_r.cnt[i] + cnt_t'(1);
        end
      end
    end
    // Writes: status is write-one-to-clear, masks are plain
    if (reg_wr_i) begin
      if (reg_addr_i == `OFF_STAT0) begin
        u_nxt.st0 = u_r.st0 & ~reg_wdata_i[5:0];
      end else if (reg_addr_i == `OFF_MASK0) begin
        u_nxt.m0 = reg_wdata_i[5:0];
      end else if (reg_addr_i == `OFF_STAT1) begin
        u_nxt.st1 = u_r.st1 & ~reg_wdata_i;
      end else if (reg_addr_i == `OFF_MASK1) begin
        u_nxt.m1 = reg_wdata_i[6:0];
      end
    end
    // Events land after the clear so a coinciding event survives
    u_nxt.st0 = u_nxt.st0 | u_nxt.ev[5:0];
    for (int j = 0; j < 5; j++) begin
      u_nxt.st1[oc_pos(j)] = u_nxt.st1[oc_pos(j)] |
                             u_nxt.ev[`CH_BUCK0 + j];
      sense1[oc_pos(j)] = u_r.s2[`CH_BUCK0 + j];
    end
    if (reg_rd_i) begin
      if (reg_addr_i == `OFF_STAT0) begin
        u_nxt.rdata = {2'h0, u_r.st0};
      end else if (reg_addr_i == `OFF_MASK0) begin
        u_nxt.rdata = {2'h0, u_r.m0};
      end else if (reg_addr_i == `OFF_SENSE0) begin
        u_nxt.rdata = {u_r.ps2, 1'b0, u_r.s2[5:0]};
      end else if (reg_addr_i == `OFF_STAT1) begin
        u_nxt.rdata = u_r.st1;
      end else if (reg_addr_i == `OFF_MASK1) begin
        u_nxt.rdata = {1'b0, u_r.m1};
      end else if (reg_addr_i == `OFF_SENSE1) begin
        u_nxt.rdata = sense1;
      end else begin
        u_nxt.rdata = '0;
      end
    end
    if (!rst_n_i) begin
      u_nxt       = '0;
      u_nxt.m0    = `MASK0_RST;
      u_nxt.m1    = `MASK1_RST;
    end
  end

  always_ff @(posedge core_clk_i) begin
    u_r <= u_nxt;
  end

  // ==========================================================
  // Outputs
  // Reserved overcurrent bits never set, so their masks are moot
  assign irq_out_n_o = ~|({u_r.st0 & ~u_r.m0,
                           u_r.st1[6:0] & ~u_r.m1});
  assign reg_rdata_o = u_r.rdata;
  assign ext_level_o = u_r.lvl[`NCH-1:`CH_EXT0];
  assign ext_event_o = u_r.ev[`NCH-1:`CH_EXT0];

  // ==========================================================
  // Checks
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_W1C_CLEARS: assert property (
    reg_wr_i && reg_addr_i == `OFF_STAT0 && reg_wdata_i[0] &&
    !u_nxt.ev[0] |=> !u_r.st0[0])
    else $error("status bit not cleared by write one");

  AST_SET_WINS: assert property (
    reg_wr_i && reg_addr_i == `OFF_STAT0 && reg_wdata_i[1] &&
    u_nxt.ev[1] |=> u_r.st0[1])
    else $error("event lost during clear");

  AST_STICKY: assert property (
    u_r.st0[2] && !(reg_wr_i && reg_addr_i == `OFF_STAT0)
    |=> u_r.st0[2])
    else $error("status bit dropped without a write");

  AST_UNMASK: assert property (
    u_r.st0[0] && reg_wr_i && reg_addr_i == `OFF_MASK0 &&
    !reg_wdata_i[0] |=> !irq_out_n_o)
    else $error("unmasked set bit did not assert line");

  AST_OC_IRQ: assert property (
    $rose(u_r.st1[0]) && !u_r.m1[0] |-> !irq_out_n_o)
    else $error("unmasked overcurrent did not assert line");

  AST_ON_TICK: assert property (
    u_r.lvl != $past(u_r.lvl) |-> $past(u_r.tick))
    else $error("debounced level moved off the tick");

  AST_OC_FULL: assert property (
    u_r.lvl[`CH_BUCK0] != $past(u_r.lvl[`CH_BUCK0]) |->
    $past(u_r.cnt[`CH_BUCK0]) == OC_TICKS - cnt_t'(1))
    else $error("overcurrent debounce too short");

  AST_RD_ZERO: assert property (
    reg_rd_i && reg_addr_i == `OFF_STAT0 |=> reg_rdata_o[7:6] == 2'h0)
    else $error("unused status bits read nonzero");

  AST_OC_RSVD: assert property (
    !u_r.st1[2] && !u_r.st1[6] && !u_r.st1[7])
    else $error("reserved overcurrent bit set");

  AST_SENSE_BTN: assert property (
    reg_rd_i && reg_addr_i == `OFF_SENSE0 |=>
    reg_rdata_o[0] == $past(u_r.s2[0]))
    else $error("button sense wrong");

  COV_IRQ: cover property ($fell(irq_out_n_o));
  COV_BTN: cover property (u_nxt.ev[`CH_BTN]);
  COV_HOT_FALL: cover property (u_nxt.ev[2] && !u_r.s2[2]);
  COV_EXT: cover property (|ext_event_o);

endmodule
`default_nettype wire

/* tb/host_model.sv */
/*
  Host side model: register port master of the interrupt unit.
  Assumes the unit's core clock; the bench calls its tasks.
*/
`default_nettype none
module host_model (
  input  wire logic       clk_i,   // Core clock
  input  wire logic [7:0] rdata_i, // Read data
  output logic [7:0]      addr_o,  // Offset
  output logic [7:0]      wdata_o, // Write data
  output logic            wr_o,    // Write strobe
  output logic            rd_o     // Read strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // ==========================================================
  // One-cycle strobes, launched just after an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
  Self-checking bench of the event interrupt unit.
  Assumes the package and the host model compiled before it.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import irq_unit_pkg::*;
  localparam int DIV = 2;
  logic       clk, rst_n, btn, lowv, boost, cfg, prog, wr, rd, irq_n;
  logic [3:0] hot;
  logic [4:0] buck;
  logic [5:0] ldo;
  logic [1:0] ext;
  byte_t      addr, wdata, rdata, lvl, evt, v;
  byte_t      ev_acc = 8'h00;
  int         num_errors, comparisons;
  byte_t      offs[7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h20};
  byte_t      rstv[7] = '{8'h00, 8'h3F, 8'h00, 8'h00, 8'h7F, 8'h00, 8'h00};

  pmic_event_interrupt_unit #(.TICK_DIV(DIV)) pmic_event_interrupt_unit_i (
    .core_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .power_button_in_i(btn), .low_input_i(lowv),
    .hot_i(hot), .buck_oc_i(buck), .boost_oc_i(boost), .ldo_oc_i(ldo),
    .cfgmem_err_i(cfg), .prog_supply_level_i(prog),
    .button_debounce_extend_i(ext), .irq_out_n_o(irq_n),
    .ext_level_o(lvl), .ext_event_o(evt));
  host_model host_model_i (.clk_i(clk), .rdata_i(rdata), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));

  // Event pulses last one cycle, so gather them for a later compare
  always @(posedge clk) ev_acc <= ev_acc | evt;

  // ==========================================================
  // Helpers
  task automatic chk(input byte_t seen, input byte_t exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Each read costs two cycles, so n bounds the wait at 2n cycles
  task automatic poll(input byte_t a, input byte_t e, input int n);
    for (int i = 0; i < n; i++) begin
      host_model_i.rd(a, v);
      if (v === e) break;
    end
    chk(v, e);
  endtask
  task automatic rchk(input byte_t a, input byte_t e);
    host_model_i.rd(a, v);
    chk(v, e);
  endtask
  task automatic wrap_up;
    $display("Compared %0d, errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog and tests
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    #2_000_000;
    num_errors++;
    $display("Error at %0t: watchdog seen 1 expected 0", $time);
    wrap_up();
  end
  initial begin
    {btn, lowv, boost, cfg, prog, hot, buck, ldo, ext} = '0;
    rst_n = 1'b0;
    step(4);
    rst_n = 1'b1;
    foreach (offs[i]) rchk(offs[i], rstv[i]);
    chk({7'h00, irq_n}, 8'h01);
    $display("Test reset done");
    hot = 4'h1;
    poll(8'h07, 8'h04, 4);
    step(20);
    hot = 4'h0;
    step(100);
    rchk(8'h05, 8'h00);
    hot = 4'h1;
    poll(8'h05, 8'h04, 80);
    chk({7'h00, irq_n}, 8'h01);
    host_model_i.wr(8'h06, 8'h3B);
    chk({7'h00, irq_n}, 8'h00);
    host_model_i.wr(8'h05, 8'h04);
    chk({7'h00, irq_n}, 8'h01);
    hot = 4'h0;
    poll(8'h05, 8'h04, 80);
    chk({7'h00, irq_n}, 8'h00);
    host_model_i.wr(8'h05, 8'hFF);
    rchk(8'h05, 8'h00);
    $display("Test thermal done");
    buck = 5'h04;
    poll(8'h0A, 8'h08, 4);
    poll(8'h08, 8'h08, 100);
    host_model_i.wr(8'h09, 8'h77);
    chk({7'h00, irq_n}, 8'h00);
    rchk(8'h09, 8'h77);
    host_model_i.wr(8'h08, 8'hFF);
    chk({7'h00, irq_n}, 8'h01);
    buck = 5'h00;
    step(200);
    rchk(8'h08, 8'h00);
    $display("Test overcurrent done");
    {lowv, boost, cfg, prog} = 4'hF;
    ldo = 6'h3F;
    ext = 2'b10;
    poll(8'h07, 8'h82, 4);
    poll(8'h05, 8'h02, 200);
    step(100);
    chk(lvl, 8'hFF);
    chk(ev_acc, 8'hFF);
    host_model_i.wr(8'h05, 8'h02);
    $display("Test low input done");
    ext = 2'b01;
    btn = 1'b1;
    poll(8'h05, 8'h01, 350);
    rchk(8'h07, 8'h83);
    host_model_i.wr(8'h05, 8'h01);
    btn = 1'b0;
    step(700);
    rchk(8'h05, 8'h00);
    poll(8'h05, 8'h01, 400);
    $display("Test button done");
    wrap_up();
  end
endmodule
`default_nettype wire
